// ---- inc/irb_pkg.sv ----
// Constants, register map and state codes for the interrupt-return and
// atomic bit execution block.
// Assumes a single core clock domain and a synchronous active-high reset.
package irb_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_SRSCTL = 8'h08;
  localparam logic [7:0] OFF_RETADDR = 8'h0c;
  localparam logic [7:0] OFF_EXCEPTION_BASE = 8'h10;
  localparam logic [7:0] OFF_SP = 8'h14;
  localparam logic [7:0] OFF_CAUSE = 8'h18;
  localparam logic [7:0] OFF_BADVA = 8'h1c;
  localparam logic [7:0] OFF_FLAGS = 8'h20;
  localparam logic [7:0] OFF_PC = 8'h24;
  localparam logic [7:0] OFF_CMD = 8'h28;
  localparam logic [7:0] OFF_BASE = 8'h2c;
  localparam logic [7:0] OFF_INFO = 8'h30;
  localparam logic [7:0] OFF_CONTEXT = 8'h34;
  localparam logic [7:0] OFF_CACHEERR = 8'h38;
  // Control register fields
  localparam int CT_APE = 0;
  localparam int CT_ICE = 1;
  localparam int CT_CLREXL = 2;
  localparam int CT_STK_LO = 4;
  localparam int CT_VS_LO = 9;
  localparam int CT_REV2 = 14;
  localparam int CT_VEIC = 15;
  localparam int CT_OPT_LO = 16;
  localparam int CT_BIGEND = 18;
  localparam int CT_REVEND = 19;
  localparam int CT_CISA = 20;
  localparam logic [31:0] CTRL_MASK = 32'h001f_fff7;
  // Status fields
  localparam int ST_IE = 0;
  localparam int ST_EXL = 1;
  localparam int ST_ERL = 2;
  localparam int ST_KSU_LO = 3;
  localparam int ST_IPL_LO = 10;
  localparam int ST_BEV = 22;
  localparam logic [31:0] STATUS_MASK = 32'h0043_fc1f;
  localparam logic [31:0] STATUS_RST = 32'h0040_0004;
  // Shadow-set control fields
  localparam int SR_CSS_LO = 0;
  localparam int SR_PSS_LO = 6;
  localparam int SR_ESS_LO = 12;
  localparam int SR_EICSS_LO = 18;
  localparam int SR_HSS_LO = 26;
  localparam logic [31:0] SRS_MASK = 32'h3c3c_f3cf;
  // Cause fields
  localparam int CA_EXC_LO = 2;
  localparam int CA_RIPL_LO = 10;
  localparam int CA_IV = 23;
  localparam int CA_IC = 24;
  localparam logic [31:0] CAUSE_MASK = 32'h0080_0000;
  // Command fields and operations
  localparam int CM_BIT_LO = 2;
  localparam int CM_OFS_LO = 5;
  localparam logic [1:0] OP_INTERRUPT_RETURN_INSTR = 2'd1;
  localparam logic [1:0] OP_ATOMIC_BIT_SET_INSTR = 2'd2;
  localparam logic [1:0] OP_ATOMIC_BIT_CLEAR_INSTR = 2'd3;
  // Stack slot offsets
  localparam logic [31:0] STK_RET = 32'h0000_0000;
  localparam logic [31:0] STK_STATUS = 32'h0000_0004;
  localparam logic [31:0] STK_SRS = 32'h0000_0008;
  // Vector formation
  localparam logic [31:0] VEC_BEV_BASE = 32'hbfc0_0200;
  localparam logic [31:0] VEC_OLD_BASE = 32'h8000_0000;
  localparam logic [31:0] VOFF_GEN = 32'h0000_0180;
  localparam logic [31:0] VOFF_IRQ = 32'h0000_0200;
  // Exception codes and memory fault kinds
  localparam logic [4:0] EXC_TLBL = 5'h02;
  localparam logic [4:0] EXC_STORE_MISS_CODE = 5'h03;
  localparam logic [4:0] EXC_ADEL = 5'h04;
  localparam logic [4:0] EXC_STORE_ADDR_ERROR_CODE = 5'h05;
  localparam logic [4:0] EXC_CACHE = 5'h1e;
  localparam logic [1:0] FLT_NONE = 2'd0;
  localparam logic [1:0] FLT_TLB = 2'd1;
  localparam logic [1:0] FLT_ADDR = 2'd2;
  localparam logic [1:0] FLT_CACHE = 2'd3;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD_ST = 3'b001,
    S_RD_SRS = 3'b010,
    S_RD_RET = 3'b011,
    S_FIN = 3'b100,
    S_A_RD = 3'b101,
    S_A_WR = 3'b110
  } irb_state_e;
endpackage

// ---- sim/irb_mem_model.sv ----
// Memory partner for irb_exec: word store, byte writes, set latency.
// Assumes the core holds mem_req until it samples mem_ack high.
`timescale 1ns/1ps
`default_nettype none
module irb_mem_model
  import irb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [1:0] fault_sel,
  input wire logic [1:0] wait_cyc,
  output logic mem_ack,
  output logic [1:0] mem_fault,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [16];
  logic [1:0] cnt;
  // Ack after wait_cyc, bus shows garbage when idle
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
    end
    else if (mem_req && !mem_ack && cnt == wait_cyc)
    begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      mem_fault <= fault_sel;
      mem_rdata <= mem[mem_addr[5:2]];
      if (mem_we && fault_sel == FLT_NONE)
        mem[mem_addr[5:2]][8*mem_addr[1:0] +: 8] <= mem_wdata[8*mem_addr[1:0] +: 8];
    end
    else
    begin
      mem_ack <= 1'b0;
      mem_fault <= ~fault_sel;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
        cnt <= cnt + 2'h1;
    end
  end
endmodule // irb_mem_model
`default_nettype wire

// ---- sim/testbench.sv ----
// Bench for irb_exec: register tasks and instruction scenarios.
// Assumes irb_mem_model answers the memory port.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import irb_pkg::*;
  logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ie_bad;
  logic [7:0] reg_addr = 0, eic_level = 0, hw_int_pending = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, mem_addr, mem_wdata, mem_rdata, pc_value, pc_v, v, code_v;
  logic [3:0] eic_set = 0;
  logic [5:0] eic_vector = 0;
  logic [1:0] mem_fault, fsel = 0, wcyc = 0;
  logic eic_ack, mem_req, mem_we, mem_byte, mem_ack, pc_load, hazard_clear, exc_valid, int_enable;
  logic [4:0] exc_code;
  int error_cnt = 0, comparisons = 0, cyc = 0, hz, acks;
  always #2.5 core_clk = ~core_clk;
  irb_exec dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eic_level(eic_level),
    .eic_set(eic_set), .eic_vector(eic_vector), .hw_int_pending(hw_int_pending),
    .eic_ack(eic_ack), .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_fault(mem_fault),
    .mem_rdata(mem_rdata), .pc_load(pc_load), .pc_value(pc_value),
    .hazard_clear(hazard_clear), .exc_valid(exc_valid), .exc_code(exc_code),
    .int_enable(int_enable));
  irb_mem_model m (.core_clk(core_clk), .rst(rst), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .fault_sel(fsel), .wait_cyc(wcyc),
    .mem_ack(mem_ack), .mem_fault(mem_fault), .mem_rdata(mem_rdata));
  // Pulse capture and hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (pc_load === 1'b1) pc_v <= pc_value;
    if (eic_ack === 1'b1) acks <= acks + 1;
    if (hazard_clear === 1'b1) hz <= hz + 1;
    if (exc_valid === 1'b1) code_v <= 32'(exc_code);
    if (mem_req === 1'b1 && int_enable !== 1'b0) ie_bad <= 1'b1;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test;
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Standalone command, never in a delay slot, then poll busy
  task automatic go(input logic [31:0] c);
    wr(OFF_CMD, c);
    v = 1;
    for (int i = 0; i < 100 && v[0] !== 1'b0; i++) rd(OFF_INFO, v);
    repeat (2) @(posedge core_clk);
  endtask
  // Scenario sequence
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 0;
    rd(OFF_STATUS, v);
    chk(v, 32'h0040_0004);
    wr(OFF_RETADDR, 32'h300);
    hz = 0;
    go(1);
    chk(pc_v, 32'h300);
    chk(hz, 1);
    wr(OFF_CTRL, 32'h0010_0021);
    wr(OFF_STATUS, 0);
    wr(OFF_SRSCTL, 0);
    wr(OFF_SP, 32'h100);
    wr(OFF_FLAGS, 1);
    m.mem[0] = 32'h201;
    m.mem[1] = 32'h1401;
    m.mem[2] = 32'h1080;
    wcyc <= 3;
    hz = 0;
    go(1);
    chk(pc_v, 32'h200);
    chk(hz, 2);
    rd(OFF_SP, v);
    chk(v, 32'h108);
    rd(OFF_STATUS, v);
    chk(v, 32'h1401);
    rd(OFF_SRSCTL, v);
    chk(v, 32'h1080);
    rd(OFF_FLAGS, v);
    chk(v, 32'h2);
    wr(OFF_CTRL, 32'h0010_0027);
    wr(OFF_SP, 32'h100);
    m.mem[1] = 32'h412;
    eic_level <= 9;
    eic_set <= 3;
    wcyc <= 0;
    acks = 0;
    hz = 0;
    go(1);
    chk(pc_v, 32'h8000_0180);
    chk(acks, 1);
    chk(hz, 2);
    rd(OFF_STATUS, v);
    chk(v, 32'h2400);
    rd(OFF_SRSCTL, v);
    chk(32'(v[3:0]), 3);
    wr(OFF_CAUSE, 32'h0080_0000);
    wr(OFF_SP, 32'h100);
    go(1);
    chk(pc_v, 32'h8000_0200);
    wr(OFF_CTRL, 32'h0012_8227);
    eic_vector <= 5;
    wr(OFF_SP, 32'h100);
    go(1);
    chk(pc_v, 32'h8000_02a0);
    wr(OFF_CTRL, 32'h0010_0021);
    wr(OFF_SP, 32'h102);
    code_v = 0;
    go(1);
    chk(code_v, 32'(EXC_ADEL));
    rd(OFF_BADVA, v);
    chk(v, 32'h106);
    wr(OFF_STATUS, 1);
    wr(OFF_BASE, 32'h40);
    m.mem[0] = 32'h8000_0101;
    ie_bad = 0;
    go(32'h2e);
    chk(m.mem[0], 32'h8000_0901);
    chk(32'(ie_bad), 0);
    chk(32'(int_enable), 1);
    wr(OFF_BASE, 32'h41);
    go(32'h0001_ffe3);
    chk(m.mem[0], 32'h8000_0900);
    for (int k = 1; k < 3; k++)
    begin
      fsel <= 2'(k);
      code_v = 0;
      go(2);
      chk(code_v, 32'(k == 1 ? EXC_STORE_MISS_CODE : EXC_STORE_ADDR_ERROR_CODE));
    end
    finish_test();
  end
endmodule // testbench
`default_nettype wire

// ---- verilog/irb_exec.sv ----
// Execution unit for the interrupt return with automated epilogue and the
// atomic byte bit set / clear instructions.
// Assumes a same-clock interrupt controller, a word memory port with
// request/acknowledge, and a register port driven by core logic.
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module irb_exec
  import irb_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] eic_level,
  input wire logic [3:0] eic_set,
  input wire logic [5:0] eic_vector,
  input wire logic [7:0] hw_int_pending,
  output logic eic_ack,
  output logic mem_req,
  output logic mem_we,
  output logic mem_byte,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [1:0] mem_fault,
  input wire logic [31:0] mem_rdata,
  output logic pc_load,
  output logic [31:0] pc_value,
  output logic hazard_clear,
  output logic exc_valid,
  output logic [4:0] exc_code,
  output logic int_enable
);
  irb_state_e state;
  logic [31:0] ctrl, status, srsctl, ret_addr, exception_base, sp, cause, bad_va;
  logic [31:0] cmd, op_base, ctx_addr, cerr_addr;
  logic link_flag, isa_mode, exc_flag, saved_ie, chain_sel;
  logic [31:0] tmp_status, tmp_srs, tmp_ret;
  logic [1:0] op;

  // Highest pending line wins
  function automatic logic [7:0] prio_enc(input logic [7:0] pend);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (pend[i])
        n = 8'(i);
    end
    return n;
  endfunction

  // Frame size in bytes from the code (words)
  function automatic logic [31:0] frame_bytes(input logic [4:0] code);
    return {25'h0000000, code, 2'b00};
  endfunction

  // Chained vector address
  function automatic logic [31:0] calc_vector(input logic [31:0] st, input logic [31:0] ca,
      input logic [31:0] ct, input logic [31:0] eb, input logic [7:0] ripl,
      input logic [5:0] evec, input logic [7:0] pend);
    logic [31:0] vbase;
    logic [31:0] voff;
    logic [7:0] vnum;
    logic [4:0] vs;
    vs = ct[CT_VS_LO +: 5];
    vnum = 8'h00;
    if (st[ST_BEV])
      vbase = VEC_BEV_BASE;
    else if (ct[CT_REV2])
      vbase = {eb[31:12], 12'h000};
    else
      vbase = VEC_OLD_BASE;
    if (ct[CT_VEIC] && ct[CT_OPT_LO +: 2] == 2'd1)
      vnum = ripl;
    else if (ct[CT_VEIC] && ct[CT_OPT_LO +: 2] == 2'd2)
      vnum = {2'b00, evec};
    else if (!ct[CT_VEIC])
      vnum = prio_enc(pend);
    if (!ca[CA_IV])
      voff = VOFF_GEN;
    else if (st[ST_BEV] || vs == 5'h00)
      voff = VOFF_IRQ;
    else
      voff = VOFF_IRQ + {19'h00000, vnum, 5'h00} * {27'h0000000, vs};
    return vbase + voff;
  endfunction

  // Decoded command and stack addresses
  logic cmd_wr, start_interrupt_return_instr, start_atomic, interrupt_return_instr_fallback, plain_path;
  logic [31:0] atom_addr, acc_addr, frame, vec_addr;
  logic [1:0] data_lane, phys_lo;
  logic [7:0] old_byte, new_byte;
  assign cmd_wr = reg_wr && reg_addr == OFF_CMD && state == S_IDLE;
  assign start_interrupt_return_instr = cmd_wr && reg_wdata[1:0] == OP_INTERRUPT_RETURN_INSTR;
  assign start_atomic = cmd_wr && reg_wdata[1] && reg_wdata[0] == OP_ATOMIC_BIT_SET_INSTR[0]
    || cmd_wr && reg_wdata[1:0] == OP_ATOMIC_BIT_CLEAR_INSTR;
  assign interrupt_return_instr_fallback = !ctrl[CT_APE] || status[ST_ERL] || status[ST_BEV];
  assign plain_path = !ctrl[CT_ICE] || tmp_status[ST_IPL_LO +: 8] >= eic_level;
  assign frame = frame_bytes(ctrl[CT_STK_LO +: 5]);
  assign atom_addr = op_base + {{20{cmd[CM_OFS_LO + 11]}}, cmd[CM_OFS_LO +: 12]};
  assign data_lane = atom_addr[1:0] ^ {2{ctrl[CT_BIGEND]}};
  assign phys_lo = atom_addr[1:0] ^ {2{ctrl[CT_REVEND]}};
  assign old_byte = mem_rdata[{data_lane, 3'b000} +: 8];
  assign new_byte = (op == OP_ATOMIC_BIT_SET_INSTR) ? (old_byte | (8'h01 << cmd[CM_BIT_LO +: 3]))
    : (old_byte & ~(8'h01 << cmd[CM_BIT_LO +: 3]));
  assign vec_addr = calc_vector(tmp_status, cause, ctrl, exception_base, eic_level, eic_vector,
    hw_int_pending);

  // Address of the access owned by the current state
  always_comb
  begin
    case (state)
      S_RD_ST: acc_addr = sp + STK_STATUS;
      S_RD_SRS: acc_addr = sp + STK_SRS;
      S_RD_RET: acc_addr = sp + STK_RET;
      default: acc_addr = atom_addr;
    endcase
  end

  // Events of the sequence
  logic stk_state, issue, misalign, got, fault, exc_fire, fin_plain, fin_chain, do_exception_return_instr;
  logic [4:0] exc_kind;
  assign stk_state = state == S_RD_ST || state == S_RD_SRS || state == S_RD_RET;
  assign issue = (stk_state || state == S_A_RD) && !mem_req;
  assign misalign = issue && stk_state && acc_addr[1:0] != 2'b00;
  assign got = mem_req && mem_ack && mem_fault == FLT_NONE;
  assign fault = mem_req && mem_ack && mem_fault != FLT_NONE;
  assign exc_fire = misalign || fault;
  assign fin_plain = state == S_FIN && plain_path;
  assign fin_chain = state == S_FIN && !plain_path;
  assign do_exception_return_instr = start_interrupt_return_instr && interrupt_return_instr_fallback;

  // Exception code: stack reads as loads, atomic as stores
  always_comb
  begin
    if (misalign)
      exc_kind = EXC_ADEL;
    else if (mem_fault == FLT_CACHE)
      exc_kind = EXC_CACHE;
    else if (mem_fault == FLT_TLB)
      exc_kind = stk_state ? EXC_TLBL : EXC_STORE_MISS_CODE;
    else
      exc_kind = stk_state ? EXC_ADEL : EXC_STORE_ADDR_ERROR_CODE;
  end

  // Sequencer and memory port
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= S_IDLE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_byte <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 32'h0000_0000;
      tmp_status <= 32'h0000_0000;
      tmp_srs <= 32'h0000_0000;
      tmp_ret <= 32'h0000_0000;
      op <= 2'b00;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          if (start_interrupt_return_instr && !interrupt_return_instr_fallback)
            state <= S_RD_ST;
          else if (start_atomic)
            state <= S_A_RD;
          if (cmd_wr)
            op <= reg_wdata[1:0];
        end
        S_RD_ST, S_RD_SRS, S_RD_RET:
        begin
          if (misalign || fault)
            state <= S_IDLE;
          else if (issue)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_byte <= 1'b0;
            mem_addr <= acc_addr;
          end
          else if (got)
          begin
            mem_req <= 1'b0;
            if (state == S_RD_ST)
            begin
              tmp_status <= mem_rdata & STATUS_MASK;
              state <= (!ctrl[CT_ICE] || mem_rdata[ST_IPL_LO +: 8] >= eic_level)
                ? S_RD_SRS : S_FIN;
            end
            else if (state == S_RD_SRS)
            begin
              tmp_srs <= mem_rdata;
              state <= S_RD_RET;
            end
            else
            begin
              tmp_ret <= mem_rdata;
              state <= S_FIN;
            end
          end
          if (fault)
            mem_req <= 1'b0;
        end
        S_FIN: state <= S_IDLE;
        S_A_RD:
        begin
          if (issue)
          begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_byte <= 1'b1;
            mem_addr <= {atom_addr[31:2], phys_lo};
          end
          else if (fault)
          begin
            mem_req <= 1'b0;
            state <= S_IDLE;
          end
          else if (got)
          begin
            mem_we <= 1'b1;
            mem_wdata <= {24'h000000, new_byte} << {data_lane, 3'b000};
            state <= S_A_WR;
          end
        end
        S_A_WR:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Status register: software writes, restore, chaining, atomic enable
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      status <= STATUS_RST;
      saved_ie <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == OFF_STATUS)
        status <= reg_wdata & STATUS_MASK;
      if (do_exception_return_instr)
      begin
        if (status[ST_ERL])
          status[ST_ERL] <= 1'b0;
        else
          status[ST_EXL] <= 1'b0;
      end
      if (fin_plain)
        status <= tmp_status;
      if (fin_chain)
      begin
        status <= tmp_status;
        status[ST_IPL_LO +: 8] <= eic_level;
        if (ctrl[CT_CLREXL])
        begin
          status[ST_EXL] <= 1'b0;
          status[ST_KSU_LO +: 2] <= 2'b00;
        end
      end
      if (start_atomic)
      begin
        saved_ie <= status[ST_IE];
        status[ST_IE] <= 1'b0;
      end
      if ((state == S_A_WR && mem_ack) || (state == S_A_RD && fault))
        status[ST_IE] <= saved_ie;
    end
  end

  // Shadow-set control, cause and stack pointer
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      srsctl <= 32'h0000_0000;
      cause <= 32'h0000_0000;
      sp <= 32'h0000_0000;
    end
    else
    begin
      if (reg_wr && reg_addr == OFF_SRSCTL)
        srsctl <= reg_wdata & SRS_MASK;
      if (reg_wr && reg_addr == OFF_CAUSE)
        cause[CA_IV] <= reg_wdata[CA_IV];
      if (reg_wr && reg_addr == OFF_SP)
        sp <= reg_wdata;
      if (exc_fire)
        cause[CA_EXC_LO +: 5] <= exc_kind;
      if (fin_plain)
      begin
        sp <= sp + frame;
        srsctl[SR_PSS_LO +: 4] <= tmp_srs[SR_PSS_LO +: 4];
        srsctl[SR_ESS_LO +: 4] <= tmp_srs[SR_ESS_LO +: 4];
        if (ctrl[CT_REV2] && srsctl[SR_HSS_LO +: 4] != 4'h0 && !tmp_status[ST_BEV])
          srsctl[SR_CSS_LO +: 4] <= tmp_srs[SR_PSS_LO +: 4];
        cause[CA_IC] <= 1'b0;
      end
      if (fin_chain)
      begin
        cause[CA_RIPL_LO +: 8] <= eic_level;
        srsctl[SR_EICSS_LO +: 4] <= eic_set;
        srsctl[SR_CSS_LO +: 4] <= eic_set;
        sp <= sp + frame;
        cause[CA_IC] <= 1'b1;
      end
    end
  end

  // Program counter, return address, link flag, barrier
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ret_addr <= 32'h0000_0000;
      link_flag <= 1'b0;
      isa_mode <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= 32'h0000_0000;
      hazard_clear <= 1'b0;
      eic_ack <= 1'b0;
    end
    else
    begin
      pc_load <= 1'b0;
      hazard_clear <= state == S_RD_ST && got;
      eic_ack <= fin_chain;
      if (reg_wr && reg_addr == OFF_RETADDR)
        ret_addr <= reg_wdata;
      if (reg_wr && reg_addr == OFF_FLAGS)
        link_flag <= reg_wdata[0];
      if (do_exception_return_instr)
      begin
        pc_load <= 1'b1;
        pc_value <= ret_addr;
        link_flag <= 1'b0;
        hazard_clear <= 1'b1;
      end
      if (fin_plain)
      begin
        ret_addr <= tmp_ret;
        pc_load <= 1'b1;
        pc_value <= ctrl[CT_CISA] ? {tmp_ret[31:1], 1'b0} : tmp_ret;
        if (ctrl[CT_CISA])
          isa_mode <= tmp_ret[0];
        link_flag <= 1'b0;
        hazard_clear <= 1'b1;
      end
      if (fin_chain)
      begin
        pc_load <= 1'b1;
        pc_value <= vec_addr;
        link_flag <= 1'b0;
        hazard_clear <= 1'b1;
      end
    end
  end

  // Fault reporting registers
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      exc_valid <= 1'b0;
      exc_code <= 5'h00;
      bad_va <= 32'h0000_0000;
      ctx_addr <= 32'h0000_0000;
      cerr_addr <= 32'h0000_0000;
      exc_flag <= 1'b0;
    end
    else
    begin
      exc_valid <= exc_fire;
      if (reg_wr && reg_addr == OFF_INFO && reg_wdata[1])
        exc_flag <= 1'b0;
      if (exc_fire)
      begin
        exc_flag <= 1'b1; // Set wins over clear
        exc_code <= exc_kind;
        if (mem_fault == FLT_CACHE && !misalign)
          cerr_addr <= mem_addr;
        else
          bad_va <= misalign ? acc_addr : mem_addr;
        if (mem_fault == FLT_TLB && !misalign)
          ctx_addr <= mem_addr;
      end
    end
  end

  // Software configuration registers, plus chain_sel set by the sequencer in S_FIN
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      ctrl <= 32'h0000_0000;
      exception_base <= VEC_OLD_BASE;
      cmd <= 32'h0000_0000;
      op_base <= 32'h0000_0000;
      chain_sel <= 1'b0;
    end
    else
    begin
      if (reg_wr && reg_addr == OFF_CTRL)
        ctrl <= reg_wdata & CTRL_MASK;
      if (reg_wr && reg_addr == OFF_EXCEPTION_BASE)
        exception_base <= {reg_wdata[31:12], 12'h000};
      if (cmd_wr)
        cmd <= reg_wdata;
      if (reg_wr && reg_addr == OFF_BASE)
        op_base <= reg_wdata;
      if (state == S_FIN)
        chain_sel <= !plain_path;
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        OFF_CTRL: reg_rdata <= ctrl;
        OFF_STATUS: reg_rdata <= status;
        OFF_SRSCTL: reg_rdata <= srsctl;
        OFF_RETADDR: reg_rdata <= ret_addr;
        OFF_EXCEPTION_BASE: reg_rdata <= exception_base;
        OFF_SP: reg_rdata <= sp;
        OFF_CAUSE: reg_rdata <= cause;
        OFF_BADVA: reg_rdata <= bad_va;
        OFF_FLAGS: reg_rdata <= {30'h00000000, isa_mode, link_flag};
        OFF_PC: reg_rdata <= pc_value;
        OFF_CMD: reg_rdata <= cmd;
        OFF_BASE: reg_rdata <= op_base;
        OFF_INFO: reg_rdata <= {29'h00000000, chain_sel, exc_flag, state != S_IDLE};
        OFF_CONTEXT: reg_rdata <= ctx_addr;
        OFF_CACHEERR: reg_rdata <= cerr_addr;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
    else
      reg_rdata <= 32'h0000_0000;
  end

  assign int_enable = status[ST_IE];

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_chain_end;
    state == S_FIN && !plain_path;
  endsequence
  link_clear_a: assert property ((fin_plain || fin_chain) |=> !link_flag)
    else $error("link flag not cleared by interrupt return");
  stack_align_a: assert property (misalign |=> exc_valid && exc_code == EXC_ADEL)
    else $error("misaligned stack read not reported");
  barrier_pc_a: assert property (pc_load |-> hazard_clear)
    else $error("jump without hazard barrier");
  fallback_ret_a: assert property (do_exception_return_instr |=> pc_load && pc_value == $past(ret_addr))
    else $error("fallback return target wrong");
  status_order_a: assert property (state == S_RD_ST && got |=> hazard_clear && !pc_load)
    else $error("status read not followed by barrier");
  frame_pop_a: assert property (fin_plain |=> sp == $past(sp) + $past(frame))
    else $error("stack pointer not popped");
  chain_level_a: assert property (s_chain_end |=> eic_ack && pc_load
      && status[ST_IPL_LO +: 8] == $past(eic_level) && cause[CA_IC])
    else $error("chained level or flag wrong");
  ie_hold_a: assert property ((state == S_A_RD || state == S_A_WR) |-> !status[ST_IE])
    else $error("interrupts enabled inside atomic sequence");
  store_code_a: assert property (fault && state == S_A_RD && mem_fault == FLT_TLB
      |=> exc_code == EXC_STORE_MISS_CODE)
    else $error("atomic miss code wrong");
endmodule // irb_exec
`default_nettype wire
